// *** verilog/ssp_consts.vh ***
// constants for the synchronous serial port pin block
// Notes on behaviour
// - transmit data pin shifts out bits from the transmit shift register
// - receive data pin samples bits into the receive shift register
// - bit clock pin is bidirectional, driven by device or by peer
// - bit clock may run continuously or gated; both work
// - synchronous mode clocks transmitter and receiver from the bit clock
// - asynchronous mode: control pin a is receive clock, in or out
// - synchronous mode: control pin a is transmitter 1 output or flag 0
// - asynchronous mode: control pin b is receive frame sync, in or out
// - synchronous mode: control pin b is transmitter 2 output or flag 1
// - frame sync pin serves both sides in sync, transmitter in async
// - frame sync pin as output drives the internal frame sync
// - unused port pins act as general-purpose I/O
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH
`define SSP_ADDR_CTRL     12'h000
`define SSP_ADDR_DIV      12'h004
`define SSP_ADDR_TXDATA   12'h008
`define SSP_ADDR_RXDATA   12'h00C
`define SSP_ADDR_STATUS   12'h010
`define SSP_ADDR_PINSEL   12'h014
`define SSP_ADDR_GPOUT    12'h018
`define SSP_ADDR_GPDIR    12'h01C
`define SSP_ADDR_GPIN     12'h020
`define SSP_ADDR_FLAGS    12'h024
// control register fields
`define SSP_CTRL_EN       0
`define SSP_CTRL_ASYNC    1
`define SSP_CTRL_CLKOUT   2
`define SSP_CTRL_FSOUT    3
`define SSP_CTRL_RCLKOUT  4
`define SSP_CTRL_RFSOUT   5
`define SSP_CTRL_A_TX     6
`define SSP_CTRL_B_TX     7
`define SSP_CTRL_GATED    8
`define SSP_CTRL_RST      16'h0000
`define SSP_DIV_RST       8'h03
`define SSP_PINSEL_RST    7'h00
`define SSP_WORD_BITS     16
`define SSP_WORD_MSB      15
`define SSP_CNT_MAX       4'hF
`endif

// *** verilog/ssp_sync2.v ***
// two-flop synchroniser for a pin or foreign-clock level
module ssp_sync2 (
    input  wire pclk,
    input  wire presetn,
    input  wire d,
    output reg  q
);
    reg meta;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // ssp_sync2

// *** verilog/ssp_clkgen.v ***
// internal bit clock divider with gating
module ssp_clkgen (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       run,
    input  wire [7:0] div,
    output reg        clk_out,
    output reg        rise,
    output reg        fall
);
    reg [7:0] cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt     <= 8'h00;
            clk_out <= 1'b0;
            rise    <= 1'b0;
            fall    <= 1'b0;
        end else begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (!run) begin
                cnt     <= 8'h00;
                clk_out <= 1'b0;
            end else if (cnt >= div) begin
                cnt     <= 8'h00;
                clk_out <= ~clk_out;
                rise    <= ~clk_out;
                fall    <= clk_out;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule // ssp_clkgen

// *** verilog/ssp_pins.v ***
// synchronous serial port pin logic with APB registers and GPIO fallback
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`include "ssp_consts.vh"
module ssp_pins (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // pin 0 transmit data
    input  wire        port0_tx_data_i,
    output wire        port0_tx_data_o,
    output wire        port0_tx_data_oe,
    // pin 1 receive data
    input  wire        port0_rx_data_i,
    output wire        port0_rx_data_o,
    output wire        port0_rx_data_oe,
    // pin 2 bit clock
    input  wire        port0_bit_clock_i,
    output wire        port0_bit_clock_o,
    output wire        port0_bit_clock_oe,
    // pin 3 control a
    input  wire        port0_ctrl_pin_a_i,
    output wire        port0_ctrl_pin_a_o,
    output wire        port0_ctrl_pin_a_oe,
    // pin 4 control b
    input  wire        port0_ctrl_pin_b_i,
    output wire        port0_ctrl_pin_b_o,
    output wire        port0_ctrl_pin_b_oe,
    // pin 5 frame sync
    input  wire        port0_frame_sync_pin_i,
    output wire        port0_frame_sync_pin_o,
    output wire        port0_frame_sync_pin_oe,
    // pin 6 second port transmit data
    input  wire        port1_tx_data_i,
    output wire        port1_tx_data_o,
    output wire        port1_tx_data_oe
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SHFT = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [15:0] ctrl;
    reg  [7:0]  div;
    reg  [6:0]  pinsel;
    reg  [6:0]  gp_out;
    reg  [6:0]  gp_dir;
    reg  [1:0]  flag_out;
    reg  [15:0] tx_word;
    reg  [15:0] tx1_word;
    reg  [15:0] tx2_word;
    reg         tx_full;
    reg  [15:0] rx_word;
    reg         rx_full;
    reg         rx_ovr;
    reg  [15:0] tx_sh;
    reg  [15:0] tx1_sh;
    reg  [15:0] tx2_sh;
    reg  [15:0] rx_sh;
    reg  [3:0]  tx_cnt;
    reg  [3:0]  rx_cnt;
    reg  [2:0]  tx_st;
    reg         rx_act;
    reg         fs_gen;
    reg         sck_d;
    reg         rck_d;

    wire [6:0]  pin_in;
    wire [6:0]  pin_s;
    wire        wr = psel & penable & pwrite;
    wire        rd = psel & penable & ~pwrite;
    wire        en = ctrl[`SSP_CTRL_EN];
    wire        async_m = ctrl[`SSP_CTRL_ASYNC];
    wire        clk_out_m = ctrl[`SSP_CTRL_CLKOUT];
    wire        rclk_out_m = ctrl[`SSP_CTRL_RCLKOUT];
    wire        gen_clk, gen_rise, gen_fall;
    wire        run_clk;
    wire        sck, rck, fs_in, rfs_in, rx_bit;
    wire        t_rise, t_fall, r_fall;

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `SSP_ADDR_CTRL) || (a == `SSP_ADDR_DIV) ||
                     (a == `SSP_ADDR_TXDATA) || (a == `SSP_ADDR_RXDATA) ||
                     (a == `SSP_ADDR_STATUS) || (a == `SSP_ADDR_PINSEL) ||
                     (a == `SSP_ADDR_GPOUT) || (a == `SSP_ADDR_GPDIR) ||
                     (a == `SSP_ADDR_GPIN) || (a == `SSP_ADDR_FLAGS);
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);

    assign pin_in = {port1_tx_data_i, port0_frame_sync_pin_i,
                     port0_ctrl_pin_b_i, port0_ctrl_pin_a_i,
                     port0_bit_clock_i, port0_rx_data_i, port0_tx_data_i};

    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : g_sync
            ssp_sync2 u_sync (
                .pclk    (pclk),
                .presetn (presetn),
                .d       (pin_in[g]),
                .q       (pin_s[g])
            );
        end
    endgenerate

    // gated clock runs only while a word is pending or shifting
    assign run_clk = en & (~ctrl[`SSP_CTRL_GATED] | tx_full |
                     (tx_st != ST_IDLE) | rx_act);

    ssp_clkgen u_clkgen (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run_clk),
        .div     (div),
        .clk_out (gen_clk),
        .rise    (gen_rise),
        .fall    (gen_fall)
    );

    // edges of the clock seen at the pin, internal or external
    assign sck    = clk_out_m ? gen_clk : pin_s[2];
    assign t_rise = sck & ~sck_d;
    assign t_fall = ~sck & sck_d;
    // receive clock: bit clock in sync, control pin a in async
    assign rck    = async_m ? (rclk_out_m ? gen_clk : pin_s[3])
                            : sck;
    assign r_fall = ~rck & rck_d;
    assign fs_in  = ctrl[`SSP_CTRL_FSOUT] ? fs_gen : pin_s[5];
    assign rfs_in = async_m ? (ctrl[`SSP_CTRL_RFSOUT] ? fs_gen : pin_s[4])
                            : fs_in;
    assign rx_bit = pin_s[1];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_d <= 1'b0;
            rck_d <= 1'b0;
        end else begin
            sck_d <= sck;
            rck_d <= rck;
        end
    end

    // register writes and hardware flag updates
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= `SSP_CTRL_RST;
            div      <= `SSP_DIV_RST;
            pinsel   <= `SSP_PINSEL_RST;
            gp_out   <= 7'h00;
            gp_dir   <= 7'h00;
            flag_out <= 2'h0;
            tx_word  <= 16'h0000;
            tx1_word <= 16'h0000;
            tx2_word <= 16'h0000;
            tx_full  <= 1'b0;
            rx_word  <= 16'h0000;
            rx_full  <= 1'b0;
            rx_ovr   <= 1'b0;
        end else begin
            if (wr) begin
                case (paddr)
                    `SSP_ADDR_CTRL:   ctrl   <= pwdata[15:0];
                    `SSP_ADDR_DIV:    div    <= pwdata[7:0];
                    `SSP_ADDR_PINSEL: pinsel <= pwdata[6:0];
                    `SSP_ADDR_GPOUT:  gp_out <= pwdata[6:0];
                    `SSP_ADDR_GPDIR:  gp_dir <= pwdata[6:0];
                    `SSP_ADDR_FLAGS:  flag_out <= pwdata[1:0];
                    default: ;
                endcase
            end
            if (wr && paddr == `SSP_ADDR_TXDATA) begin
                tx_word  <= pwdata[15:0];
                tx1_word <= pwdata[31:16];
                tx2_word <= pwdata[31:16];
            end
            // a fresh write wins over a load into the shifter and keeps tx_full set
            if (wr && paddr == `SSP_ADDR_TXDATA)
                tx_full <= 1'b1;
            else if (en && tx_st == ST_IDLE && tx_full && fs_in && t_rise)
                tx_full <= 1'b0;
            // capture sets beat a software read clear
            if (rx_act && r_fall && rx_cnt == 4'h0) begin
                rx_word <= {rx_sh[14:0], rx_bit};
                rx_full <= 1'b1;
                if (rx_full && !(rd && paddr == `SSP_ADDR_RXDATA))
                    rx_ovr <= 1'b1;
            end else if (rd && paddr == `SSP_ADDR_RXDATA) begin
                rx_full <= 1'b0;
            end
            if (wr && paddr == `SSP_ADDR_STATUS && pwdata[2] &&
                !(rx_act && r_fall && rx_cnt == 4'h0 && rx_full))
                rx_ovr <= 1'b0;
        end
    end

    // transmit state machine: load on frame sync, shift on rising edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st  <= ST_IDLE;
            tx_sh  <= 16'h0000;
            tx1_sh <= 16'h0000;
            tx2_sh <= 16'h0000;
            tx_cnt <= 4'h0;
            fs_gen <= 1'b0;
        end else if (!en) begin
            tx_st  <= ST_IDLE;
            fs_gen <= 1'b0;
        end else begin
            if (gen_fall)
                fs_gen <= (tx_st == ST_IDLE) & tx_full;
            case (tx_st)
                ST_IDLE: if (t_rise && fs_in && tx_full) begin
                    tx_sh  <= tx_word;
                    tx1_sh <= tx1_word;
                    tx2_sh <= tx2_word;
                    tx_cnt <= `SSP_CNT_MAX;
                    tx_st  <= ST_SHFT;
                end
                ST_SHFT: if (t_rise) begin
                    tx_sh  <= {tx_sh[14:0], 1'b0};
                    tx1_sh <= {tx1_sh[14:0], 1'b0};
                    tx2_sh <= {tx2_sh[14:0], 1'b0};
                    if (tx_cnt == 4'h1)
                        tx_st <= ST_DONE;
                    tx_cnt <= tx_cnt - 4'h1;
                end
                // last bit is sampled on the falling edge, so a peer that
                // stops its clock after the frame still lets us go idle
                ST_DONE: if (t_fall)
                    tx_st <= ST_IDLE;
                default: tx_st <= ST_IDLE;
            endcase
        end
    end

    // receive shifter samples on falling receive clock after frame sync
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_act <= 1'b0;
            rx_sh  <= 16'h0000;
            rx_cnt <= 4'h0;
        end else if (!en) begin
            rx_act <= 1'b0;
        end else if (r_fall) begin
            if (!rx_act && rfs_in) begin
                rx_act <= 1'b1;
                rx_sh  <= {15'h0000, rx_bit};
                rx_cnt <= 4'hE;
            end else if (rx_act) begin
                rx_sh  <= {rx_sh[14:0], rx_bit};
                rx_cnt <= rx_cnt - 4'h1;
                if (rx_cnt == 4'h0)
                    rx_act <= 1'b0;
            end
        end
    end

    // per-pin function, drive value and enable
    wire [6:0] fn_o, fn_oe, pin_o, pin_oe;
    wire       tx_live = (tx_st != ST_IDLE);
    assign fn_o[0]  = tx_sh[`SSP_WORD_MSB];
    assign fn_oe[0] = tx_live;
    assign fn_o[1]  = 1'b0;
    assign fn_oe[1] = 1'b0;
    assign fn_o[2]  = gen_clk;
    assign fn_oe[2] = clk_out_m;
    assign fn_o[3]  = async_m ? gen_clk :
                      (ctrl[`SSP_CTRL_A_TX] ? tx1_sh[`SSP_WORD_MSB]
                                            : flag_out[0]);
    assign fn_oe[3] = async_m ? rclk_out_m : 1'b1;
    assign fn_o[4]  = async_m ? fs_gen :
                      (ctrl[`SSP_CTRL_B_TX] ? tx2_sh[`SSP_WORD_MSB]
                                            : flag_out[1]);
    assign fn_oe[4] = async_m ? ctrl[`SSP_CTRL_RFSOUT] : 1'b1;
    assign fn_o[5]  = fs_gen;
    assign fn_oe[5] = ctrl[`SSP_CTRL_FSOUT];
    assign fn_o[6]  = tx_sh[`SSP_WORD_MSB];
    assign fn_oe[6] = tx_live;

    generate
        for (g = 0; g < 7; g = g + 1) begin : g_mux
            // serial function only when selected and port enabled
            assign pin_o[g]  = (pinsel[g] & en) ? fn_o[g] : gp_out[g];
            assign pin_oe[g] = (pinsel[g] & en) ? fn_oe[g]
                                                : gp_dir[g];
        end
    endgenerate

    assign {port1_tx_data_o, port0_frame_sync_pin_o, port0_ctrl_pin_b_o,
            port0_ctrl_pin_a_o, port0_bit_clock_o, port0_rx_data_o,
            port0_tx_data_o} = pin_o;
    assign {port1_tx_data_oe, port0_frame_sync_pin_oe, port0_ctrl_pin_b_oe,
            port0_ctrl_pin_a_oe, port0_bit_clock_oe, port0_rx_data_oe,
            port0_tx_data_oe} = pin_oe;

    // read mux
    always @* begin
        case (paddr)
            `SSP_ADDR_CTRL:   prdata = {16'h0000, ctrl};
            `SSP_ADDR_DIV:    prdata = {24'h000000, div};
            `SSP_ADDR_TXDATA: prdata = {tx1_word, tx_word};
            `SSP_ADDR_RXDATA: prdata = {16'h0000, rx_word};
            `SSP_ADDR_STATUS: prdata = {27'h0000000, tx_live, rx_act,
                                        rx_ovr, rx_full, tx_full};
            `SSP_ADDR_PINSEL: prdata = {25'h0000000, pinsel};
            `SSP_ADDR_GPOUT:  prdata = {25'h0000000, gp_out};
            `SSP_ADDR_GPDIR:  prdata = {25'h0000000, gp_dir};
            `SSP_ADDR_GPIN:   prdata = {25'h0000000, pin_s};
            `SSP_ADDR_FLAGS:  prdata = {27'h0000000, pin_s[4], pin_s[3],
                                        1'b0, flag_out};
            default:          prdata = 32'h00000000;
        endcase
    end
endmodule // ssp_pins

// *** sim/ssp_checker.sv ***
// port-level assertions for the serial port pin block
`include "ssp_consts.vh"
module ssp_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    input wire        port0_tx_data_o,
    input wire        port0_tx_data_oe,
    input wire        port0_rx_data_o,
    input wire        port0_rx_data_oe,
    input wire        port0_bit_clock_o,
    input wire        port0_bit_clock_oe,
    input wire        port0_ctrl_pin_a_o,
    input wire        port0_ctrl_pin_a_oe,
    input wire        port0_ctrl_pin_b_o,
    input wire        port0_ctrl_pin_b_oe,
    input wire        port0_frame_sync_pin_o,
    input wire        port0_frame_sync_pin_oe,
    input wire        port1_tx_data_o,
    input wire        port1_tx_data_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [8:0] ctl;
    logic [6:0] psl;
    logic [6:0] dir;
    logic [6:0] gout;
    logic [1:0] flg;
    wire  [6:0] ov = {port1_tx_data_o, port0_frame_sync_pin_o,
        port0_ctrl_pin_b_o, port0_ctrl_pin_a_o, port0_bit_clock_o,
        port0_rx_data_o, port0_tx_data_o};
    wire  [6:0] ev = {port1_tx_data_oe, port0_frame_sync_pin_oe,
        port0_ctrl_pin_b_oe, port0_ctrl_pin_a_oe, port0_bit_clock_oe,
        port0_rx_data_oe, port0_tx_data_oe};
    wire  [6:0] sel = psl & {7{ctl[0]}};
    wire        run = sel[2] & ctl[2] & ~ctl[8];
    // shadow copies of the registers that steer the pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 9'h000;
            psl <= 7'h00;
            dir <= 7'h00;
            gout <= 7'h00;
            flg <= 2'h0;
        end else if (psel && penable && pwrite && !pslverr) begin
            case (paddr)
                `SSP_ADDR_CTRL: ctl <= pwdata[8:0];
                `SSP_ADDR_PINSEL: psl <= pwdata[6:0];
                `SSP_ADDR_GPOUT: gout <= pwdata[6:0];
                `SSP_ADDR_GPDIR: dir <= pwdata[6:0];
                `SSP_ADDR_FLAGS: flg <= pwdata[1:0];
                default: ;
            endcase
        end
    end
    gpio_dir_a: assert property ((ev & ~sel) == (dir & ~sel))
        else $error("gpio direction wrong");
    gpio_out_a: assert property (
        (ov & dir & ~sel) == (gout & dir & ~sel))
        else $error("gpio output level wrong");
    rx_input_a: assert property (sel[1] |-> !port0_rx_data_oe)
        else $error("receive pin driven");
    clk_dir_a: assert property (
        sel[2] |-> port0_bit_clock_oe == ctl[2])
        else $error("bit clock direction wrong");
    fs_dir_a: assert property (
        sel[5] |-> port0_frame_sync_pin_oe == ctl[3])
        else $error("frame sync direction wrong");
    pin_a_role_a: assert property (sel[3] |->
        port0_ctrl_pin_a_oe == (ctl[1] ? ctl[4] : 1'b1))
        else $error("control pin a direction wrong");
    pin_b_role_a: assert property (sel[4] |->
        port0_ctrl_pin_b_oe == (ctl[1] ? ctl[5] : 1'b1))
        else $error("control pin b direction wrong");
    flag_out_a: assert property (sel[4:3] == 2'b11 &&
        ctl[7:6] == 2'b00 && !ctl[1] |->
        {port0_ctrl_pin_b_o, port0_ctrl_pin_a_o} == flg)
        else $error("flag outputs wrong");
    tx_mirror_a: assert property (sel[0] && sel[6] |->
        port1_tx_data_oe == port0_tx_data_oe &&
        port1_tx_data_o == port0_tx_data_o)
        else $error("transmit pins disagree");
    clk_run_a: assert property (run |-> ##[1:20]
        ($changed(port0_bit_clock_o) || !run))
        else $error("bit clock stalled");
    cover property (run);
    cover property (sel[3] && ctl[1]);
    cover property (sel[3] && ctl[6] && !ctl[1]);
endmodule // ssp_checker

bind ssp_pins ssp_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .port0_tx_data_o(port0_tx_data_o), .port0_tx_data_oe(port0_tx_data_oe),
    .port0_rx_data_o(port0_rx_data_o), .port0_rx_data_oe(port0_rx_data_oe),
    .port0_bit_clock_o(port0_bit_clock_o),
    .port0_bit_clock_oe(port0_bit_clock_oe),
    .port0_ctrl_pin_a_o(port0_ctrl_pin_a_o),
    .port0_ctrl_pin_a_oe(port0_ctrl_pin_a_oe),
    .port0_ctrl_pin_b_o(port0_ctrl_pin_b_o),
    .port0_ctrl_pin_b_oe(port0_ctrl_pin_b_oe),
    .port0_frame_sync_pin_o(port0_frame_sync_pin_o),
    .port0_frame_sync_pin_oe(port0_frame_sync_pin_oe),
    .port1_tx_data_o(port1_tx_data_o), .port1_tx_data_oe(port1_tx_data_oe)
);

// *** sim/ssp_peer.sv ***
// external serial peer that clocks frames into and out of the port
module ssp_peer (
    input  wire         drive,
    input  wire         async_m,
    input  wire         start,
    input  wire  [15:0] rx_word,
    input  wire  [6:0]  w,
    output logic [6:0]  p_o,
    output wire  [6:0]  p_oe,
    output logic        busy,
    output logic [15:0] cap,
    output logic [15:0] cap_a
);
    timeunit 1ns;
    timeprecision 100ps;
    assign p_oe = drive ? {2'b01, async_m, async_m, 3'b110}
                        : 7'h00;
    initial begin
        p_o = 7'h00;
        busy = 1'b0;
        cap = 16'h0000;
        cap_a = 16'h0000;
    end
    // clock runs only within a frame, 125 ns period
    always @(posedge start) begin
        busy = 1'b1;
        for (int b = 15; b >= 0; b--) begin
            p_o[3:2] = 2'b11;
            p_o[5] = (b == 15);
            p_o[4] = (b == 15);
            p_o[1] = rx_word[b];
            #62.5;
            p_o[3:2] = 2'b00;
            cap = {cap[14:0], w[0]};
            cap_a = {cap_a[14:0], w[3]};
            #62.5;
        end
        p_o[5:4] = 2'b00;
        p_o[1] = ~rx_word[0];
        busy = 1'b0;
    end
endmodule // ssp_peer

// *** sim/ssp_pins_bench.sv ***
// self-checking bench for the serial port pin block
`include "ssp_consts.vh"
module ssp_pins_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, start, drive, async_m;
    logic        err, b;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [15:0] rx_word;
    logic [6:0]  ext;
    wire  [31:0] prdata;
    wire         pready, pslverr, busy;
    wire  [15:0] cap, cap_a;
    wire  [6:0]  w, dut_o, dut_oe, p_o, p_oe;
    int          err_total, cmp_count, cyc;
    assign w = (dut_oe & dut_o) | (~dut_oe & p_oe & p_o)
        | (~dut_oe & ~p_oe & ext);
    ssp_pins dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .port0_tx_data_i(w[0]), .port0_tx_data_o(dut_o[0]),
        .port0_tx_data_oe(dut_oe[0]), .port0_rx_data_i(w[1]),
        .port0_rx_data_o(dut_o[1]), .port0_rx_data_oe(dut_oe[1]),
        .port0_bit_clock_i(w[2]), .port0_bit_clock_o(dut_o[2]),
        .port0_bit_clock_oe(dut_oe[2]), .port0_ctrl_pin_a_i(w[3]),
        .port0_ctrl_pin_a_o(dut_o[3]), .port0_ctrl_pin_a_oe(dut_oe[3]),
        .port0_ctrl_pin_b_i(w[4]), .port0_ctrl_pin_b_o(dut_o[4]),
        .port0_ctrl_pin_b_oe(dut_oe[4]), .port0_frame_sync_pin_i(w[5]),
        .port0_frame_sync_pin_o(dut_o[5]), .port0_frame_sync_pin_oe(dut_oe[5]),
        .port1_tx_data_i(w[6]), .port1_tx_data_o(dut_o[6]),
        .port1_tx_data_oe(dut_oe[6])
    );
    ssp_peer peer (
        .drive(drive), .async_m(async_m), .start(start), .rx_word(rx_word),
        .w(w), .p_o(p_o), .p_oe(p_oe), .busy(busy), .cap(cap), .cap_a(cap_a)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        rd = ~v;
        for (int n = 0; n < 200 && (rd & m) !== v; n++)
            apb(1'b0, `SSP_ADDR_STATUS, 32'h0);
    endtask
    task automatic frame(input logic [15:0] rw);
        rx_word <= rw;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        while (busy === 1'b1)
            @(posedge pclk);
    endtask
    task automatic rx_check(input logic [15:0] exp);
        poll(32'h2, 32'h2);
        check(rd[1], 1'b1);
        apb(1'b0, `SSP_ADDR_RXDATA, 32'h0);
        check(rd[15:0], exp);
        apb(1'b0, `SSP_ADDR_STATUS, 32'h0);
        check(rd[1], 1'b0);
    endtask
    task automatic t_reset;
        check({25'h0, dut_oe}, 32'h0);
        apb(1'b0, `SSP_ADDR_DIV, 32'h0);
        check(rd, {24'h0, `SSP_DIV_RST});
        apb(1'b0, `SSP_ADDR_PINSEL, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic t_gpio;
        apb(1'b1, `SSP_ADDR_GPDIR, 32'h55);
        apb(1'b1, `SSP_ADDR_GPOUT, 32'h7F);
        check({25'h0, dut_oe}, 32'h55);
        check({25'h0, dut_o & dut_oe}, 32'h55);
        apb(1'b0, `SSP_ADDR_GPIN, 32'h0);
        check(rd, 32'h5F);
        apb(1'b1, 12'h030, 32'hF);
        check({rd[30:0], err}, 32'h1);
    endtask
    task automatic t_flag;
        apb(1'b1, `SSP_ADDR_PINSEL, 32'h7F);
        apb(1'b1, `SSP_ADDR_CTRL, 32'h1);
        apb(1'b1, `SSP_ADDR_FLAGS, 32'h3);
        check({28'h0, dut_o[4:3], dut_oe[4:3]}, 32'hF);
        apb(1'b1, `SSP_ADDR_FLAGS, 32'h1);
        check({30'h0, dut_o[4:3]}, 32'h1);
    endtask
    task automatic t_sync;
        drive <= 1'b1;
        apb(1'b1, `SSP_ADDR_CTRL, 32'hC1);
        apb(1'b1, `SSP_ADDR_TXDATA, 32'h3C96A5C3);
        frame(16'h5A3C);
        check(cap, 16'hA5C3);
        check(cap_a, 16'h3C96);
        rx_check(16'h5A3C);
    endtask
    task automatic t_async;
        apb(1'b1, `SSP_ADDR_CTRL, 32'h3);
        async_m <= 1'b1;
        apb(1'b1, `SSP_ADDR_TXDATA, 32'hC001);
        frame(16'h1234);
        check(cap, 16'hC001);
        rx_check(16'h1234);
    endtask
    task automatic t_master;
        drive <= 1'b0;
        async_m <= 1'b0;
        apb(1'b1, `SSP_ADDR_CTRL, 32'hD);
        apb(1'b1, `SSP_ADDR_TXDATA, 32'hF00F);
        for (int n = 0; n < 300 && w[5] !== 1'b1; n++)
            @(posedge pclk);
        check({dut_oe[5], w[5], dut_oe[2]}, 3'b111);
        poll(32'h1, 32'h0);
        check(rd[0], 1'b0);
        apb(1'b1, `SSP_ADDR_CTRL, 32'h10D);
        poll(32'h18, 32'h0);
        repeat (8) @(posedge pclk);
        b = w[2];
        repeat (40) @(posedge pclk);
        check(w[2], b);
    endtask
    task automatic test_done;
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, start, drive, async_m} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        rx_word = 16'h0000;
        ext = 7'h0A;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_gpio;
        t_flag;
        t_sync;
        t_async;
        t_master;
        test_done;
    end
endmodule // ssp_pins_bench
